// file: hw/tpg_top.sv
// Test pattern generator and cursor overlay with an Avalon-MM register slave.
`timescale 1ns/1ns
module tpg_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [tpg_pkg::ADDR_W+1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Upstream pixel stream from the array, asynchronous
  input wire logic pix_clk_in,
  input wire logic frame_valid_in,
  input wire logic line_valid_in,
  input wire logic embedded_row_in,
  input wire logic [tpg_pkg::PIX_W-1:0] pixel_in,
  input wire logic [tpg_pkg::COORD_W-1:0] array_row_in,
  input wire logic [tpg_pkg::COORD_W-1:0] array_col_in,
  // Pixel link to the receiver
  output logic pixel_clock_out,
  output logic frame_valid_out,
  output logic line_valid_out,
  output logic [tpg_pkg::PIX_W-1:0] pixel_out,
  output logic ten_bit_raw_format,
  output logic eight_bit_raw_format,
  output logic packing_bypass,
  output logic [15:0] frame_descriptor
);
  import tpg_pkg::*;

  localparam int BUN_W = 4 + PIX_W + 2 * COORD_W;

  // Register file
  logic [8:0] mode_reg;
  logic [9:0] fill_red_reg;
  logic [9:0] fill_value_green_on_red_row_reg;
  logic [9:0] fill_blue_reg;
  logic [9:0] fill_value_green_on_blue_row_reg;
  logic [11:0] hcur_pos_reg;
  logic [11:0] hcur_width_reg;
  logic [11:0] vcur_pos_reg;
  logic [11:0] vcur_width_reg;
  logic [1:0] orient_reg;
  logic [11:0] x_start_reg;
  logic format_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // Bus decode
  logic bus_req;
  logic write_fire;
  logic [3:0] word_idx;
  logic [31:0] rdata_next;

  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_reg;
  assign write_fire = avs_write & ack_reg;
  assign word_idx = avs_address[ADDR_W+1:2];
  assign avs_readdata = rdata_reg;

  // Merges the low two byte lanes into a stored field
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [15:0] m;
    m = old;
    if (be[0]) begin
      m[7:0] = wd[7:0];
    end
    if (be[1]) begin
      m[15:8] = wd[15:8];
    end
    return m;
  endfunction

  function automatic logic wr_hit(input logic fire, input logic [3:0] idx,
                                  input logic [3:0] target);
    return fire & (idx == target);
  endfunction

  // Pin synchroniser, three stages
  logic [BUN_W-1:0] sync1_reg;
  logic [BUN_W-1:0] sync2_reg;
  logic [BUN_W-1:0] sync3_reg;
  logic [BUN_W-1:0] bundle_in;

  assign bundle_in = {array_col_in, array_row_in, pixel_in, embedded_row_in, line_valid_in,
                      frame_valid_in, pix_clk_in};

  genvar gi;
  generate
    for (gi = 0; gi < BUN_W; gi++) begin : g_sync
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= bundle_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  // Sampled stream fields
  logic pclk_lvl_reg;
  logic pix_rise;
  logic fv;
  logic lv;
  logic emb;
  logic [9:0] pix;
  logic [11:0] row;
  logic [11:0] col;

  assign pix_rise = (sync2_reg[0] == sync3_reg[0]) & sync3_reg[0] & ~pclk_lvl_reg;
  assign fv = sync3_reg[1];
  assign lv = sync3_reg[2] & fv;
  assign emb = sync3_reg[3];
  assign pix = sync3_reg[13:4];
  assign row = sync3_reg[25:14];
  assign col = sync3_reg[37:26];

  // Frame and line timing state
  logic fv_prev_reg;
  logic lv_prev_reg;
  logic emb_prev_reg;
  logic [9:0] row_cnt_reg;
  logic [10:0] auto_pos_reg;
  logic [15:0] frame_cnt_reg;
  logic [3:0] walk_step_reg;
  logic walk_half_reg;
  logic pclk_out_reg;

  logic frame_start;
  logic line_start;
  logic line_end;

  assign frame_start = pix_rise & fv & ~fv_prev_reg;
  assign line_start = lv & ~lv_prev_reg;
  assign line_end = pix_rise & ~lv & lv_prev_reg;

  // Mode decode
  logic is_prbs;
  logic is_walk;
  logic walk_eight;
  logic is_overlay_mode;

  assign is_prbs = (mode_reg == MODE_PRBS);
  assign walk_eight = (mode_reg == MODE_WALK8);
  assign is_walk = (mode_reg == MODE_WALK10) | walk_eight;
  // Cursors over image and patterns 1-3
  assign is_overlay_mode = (mode_reg == MODE_NORMAL) | (mode_reg == MODE_SOLID) |
                           (mode_reg == MODE_BARS) | (mode_reg == MODE_FADE);

  // Bayer site fill; green-on-red at even row and even column
  function automatic logic [1:0] bayer_site(input logic r0, input logic c0);
    return {r0, c0};
  endfunction

  logic [1:0] site;
  logic [9:0] site_fill;

  assign site = bayer_site(row[0], col[0]);
  assign site_fill = (site == 2'b00) ? fill_value_green_on_red_row_reg :
                     (site == 2'b01) ? fill_red_reg :
                     (site == 2'b10) ? fill_blue_reg : fill_value_green_on_blue_row_reg;

  // Bar colours, white first; bits are red, green, blue
  function automatic logic [2:0] bar_rgb(input logic [2:0] idx);
    logic [2:0] c;
    c = 3'b000;
    unique case (idx)
      3'h0: c = 3'b111;
      3'h1: c = 3'b110;
      3'h2: c = 3'b011;
      3'h3: c = 3'b010;
      3'h4: c = 3'b101;
      3'h5: c = 3'b100;
      3'h6: c = 3'b001;
      3'h7: c = 3'b000;
    endcase
    return c;
  endfunction

  logic [11:0] rel_col;
  logic bars_rev;
  logic fade_rev;
  logic [2:0] bar_idx;
  logic [2:0] rgb;
  logic comp_on;

  // Bars start at window column, 256 wide, repeat 2048
  assign rel_col = col - x_start_reg;
  // Column reversal only for full bars
  assign bars_rev = orient_reg[ORIENT_COL_REV_BIT];
  // Either orientation bit reverses fade bars
  assign fade_rev = orient_reg[ORIENT_COL_REV_BIT] | orient_reg[ORIENT_ROW_FLIP_BIT];
  assign bar_idx = ((mode_reg == MODE_FADE) ? fade_rev : bars_rev) ? ~rel_col[10:8]
                                                                    : rel_col[10:8];
  assign rgb = bar_rgb(bar_idx);
  assign comp_on = (site == 2'b01) ? rgb[2] : (site == 2'b10) ? rgb[0] : rgb[1];

  logic [9:0] bars_value;
  logic [9:0] fade_row;
  logic [9:0] fade_value;

  assign bars_value = comp_on ? FULL_SCALE : 10'h000;
  // Right half holds level for 16 rows
  assign fade_row = rel_col[7] ? {row_cnt_reg[9:4], 4'h0} : row_cnt_reg;
  // Full to half intensity over 1024 rows
  assign fade_value = comp_on ? (FULL_SCALE - {1'b0, fade_row[9:1]}) : {1'b0, fade_row[9:1]};

  // Walking value for a step index
  function automatic logic [9:0] walk_value(input logic [3:0] k, input logic eight);
    logic [9:0] v;
    if (k == 4'h0) begin
      v = 10'h000;
    end else if (k == (eight ? WALK_LAST8 : WALK_LAST10)) begin
      v = eight ? EIGHT_FULL : FULL_SCALE;
    end else begin
      v = 10'(10'h001 << (k - 4'h1));
    end
    return v;
  endfunction

  logic [3:0] walk_k;
  logic walk_h;
  logic [9:0] walk_pix;
  logic walk_wrap;

  assign walk_k = line_start ? 4'h0 : walk_step_reg;
  assign walk_h = line_start ? 1'b0 : walk_half_reg;
  // Each value for two pixel clocks
  assign walk_pix = walk_value(walk_k, walk_eight);
  assign walk_wrap = walk_h & (walk_k == (walk_eight ? WALK_LAST8 : WALK_LAST10));

  logic prbs_load;
  logic prbs_step;
  logic [9:0] prbs_word;

  assign prbs_load = ~fv | frame_start;
  assign prbs_step = pix_rise & lv & is_prbs & ~frame_start;

  tpg_prbs9 u_prbs (
    .core_clk(core_clk),
    .rst(rst),
    .load(prbs_load),
    .step(prbs_step),
    .word(prbs_word)
  );

  // Cursors
  logic [11:0] hpos;
  logic [11:0] hwid;
  logic [11:0] vpos;
  logic [11:0] vwid;
  logic h_hit;
  logic v_hit;

  assign hpos = {hcur_pos_reg[11:1], 1'b0};
  assign hwid = {hcur_width_reg[11:1], 1'b0};
  assign vwid = {vcur_width_reg[11:1], 1'b0};
  assign vpos = (vcur_pos_reg == AUTO_CURSOR_CODE) ? {1'b0, auto_pos_reg}
                                                   : {vcur_pos_reg[11:1], 1'b0};
  assign h_hit = (hwid != 12'h000) & (row >= hpos) &
                 ({1'b0, row} < ({1'b0, hpos} + {1'b0, hwid}));
  assign v_hit = (vwid != 12'h000) & (col >= vpos) &
                 ({1'b0, col} < ({1'b0, vpos} + {1'b0, vwid}));

  // Pixel selection
  logic [9:0] pattern_pix;
  logic [9:0] out_pix;
  logic out_lv;

  assign pattern_pix = (mode_reg == MODE_SOLID) ? site_fill :
                       (mode_reg == MODE_BARS) ? bars_value :
                       (mode_reg == MODE_FADE) ? fade_value :
                       is_prbs ? prbs_word :
                       is_walk ? walk_pix : pix;
  // Embedded rows pass for every code except 4
  assign out_pix = ~out_lv ? 10'h000 :
                   (emb & ~is_prbs) ? pix :
                   (is_overlay_mode & (h_hit | v_hit)) ? site_fill : pattern_pix;
  // Embedded rows dropped for code 4
  assign out_lv = lv & ~(emb & is_prbs);

  // Register read mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (word_idx)
      REG_MODE: rdata_next[8:0] = mode_reg;
      REG_FILL_RED: rdata_next[9:0] = fill_red_reg;
      REG_FILL_GR: rdata_next[9:0] = fill_value_green_on_red_row_reg;
      REG_FILL_BLUE: rdata_next[9:0] = fill_blue_reg;
      REG_FILL_GB: rdata_next[9:0] = fill_value_green_on_blue_row_reg;
      REG_HCUR_POS: rdata_next[11:0] = hcur_pos_reg;
      REG_HCUR_WIDTH: rdata_next[11:0] = hcur_width_reg;
      REG_VCUR_POS: rdata_next[11:0] = vcur_pos_reg;
      REG_VCUR_WIDTH: rdata_next[11:0] = vcur_width_reg;
      REG_ORIENT: rdata_next[1:0] = orient_reg;
      REG_X_START: rdata_next[11:0] = x_start_reg;
      REG_FORMAT: rdata_next[0] = format_reg;
      REG_STATUS: rdata_next = {5'h00, auto_pos_reg, row_cnt_reg, 5'h00, fv};
      REG_FRAMES: rdata_next[15:0] = frame_cnt_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Bus handshake
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      rdata_reg <= (avs_read & ~ack_reg) ? rdata_next : rdata_reg;
    end
  end

  // Register writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= RST_MODE;
      fill_red_reg <= RST_FILL;
      fill_value_green_on_red_row_reg <= RST_FILL;
      fill_blue_reg <= RST_FILL;
      fill_value_green_on_blue_row_reg <= RST_FILL;
      hcur_pos_reg <= RST_COORD;
      hcur_width_reg <= RST_COORD;
      vcur_pos_reg <= RST_COORD;
      vcur_width_reg <= RST_COORD;
      orient_reg <= 2'h0;
      x_start_reg <= RST_COORD;
      format_reg <= 1'b0;
    end else begin
      if (wr_hit(write_fire, word_idx, REG_MODE))
        mode_reg <= 9'(lane_merge({7'h00, mode_reg}, avs_writedata, avs_byteenable));
      if (wr_hit(write_fire, word_idx, REG_FILL_RED))
        fill_red_reg <= 10'(lane_merge({6'h00, fill_red_reg}, avs_writedata, avs_byteenable));
      if (wr_hit(write_fire, word_idx, REG_FILL_GR))
        fill_value_green_on_red_row_reg <= 10'(lane_merge({6'h00, fill_value_green_on_red_row_reg},
                                                           avs_writedata, avs_byteenable));
      if (wr_hit(write_fire, word_idx, REG_FILL_BLUE))
        fill_blue_reg <= 10'(lane_merge({6'h00, fill_blue_reg}, avs_writedata, avs_byteenable));
      if (wr_hit(write_fire, word_idx, REG_FILL_GB))
        fill_value_green_on_blue_row_reg <= 10'(lane_merge({6'h00, fill_value_green_on_blue_row_reg},
                                                            avs_writedata, avs_byteenable));
      if (wr_hit(write_fire, word_idx, REG_HCUR_POS))
        hcur_pos_reg <= 12'(lane_merge({4'h0, hcur_pos_reg}, avs_writedata, avs_byteenable));
      if (wr_hit(write_fire, word_idx, REG_HCUR_WIDTH))
        hcur_width_reg <= 12'(lane_merge({4'h0, hcur_width_reg}, avs_writedata, avs_byteenable));
      if (wr_hit(write_fire, word_idx, REG_VCUR_POS))
        vcur_pos_reg <= 12'(lane_merge({4'h0, vcur_pos_reg}, avs_writedata, avs_byteenable));
      if (wr_hit(write_fire, word_idx, REG_VCUR_WIDTH))
        vcur_width_reg <= 12'(lane_merge({4'h0, vcur_width_reg}, avs_writedata, avs_byteenable));
      if (wr_hit(write_fire, word_idx, REG_ORIENT) & avs_byteenable[0])
        orient_reg <= avs_writedata[1:0];
      if (wr_hit(write_fire, word_idx, REG_X_START))
        x_start_reg <= 12'(lane_merge({4'h0, x_start_reg}, avs_writedata, avs_byteenable));
      if (wr_hit(write_fire, word_idx, REG_FORMAT) & avs_byteenable[0])
        format_reg <= avs_writedata[FORMAT_EIGHT_BIT];
    end
  end

  // Stream timing counters
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pclk_lvl_reg <= 1'b0;
      fv_prev_reg <= 1'b0;
      lv_prev_reg <= 1'b0;
      emb_prev_reg <= 1'b0;
      row_cnt_reg <= 10'h000;
      auto_pos_reg <= 11'h000;
      frame_cnt_reg <= 16'h0000;
      walk_step_reg <= 4'h0;
      walk_half_reg <= 1'b0;
    end else begin
      if (sync2_reg[0] == sync3_reg[0])
        pclk_lvl_reg <= sync3_reg[0];
      if (pix_rise) begin
        fv_prev_reg <= fv;
        lv_prev_reg <= lv;
        emb_prev_reg <= emb;
      end
      if (frame_start) begin
        row_cnt_reg <= 10'h000;
        frame_cnt_reg <= frame_cnt_reg + 16'h0001;
      // Embedded flag is already low at line end; use the last pixel's
      end else if (line_end & ~emb_prev_reg) begin
        row_cnt_reg <= row_cnt_reg + 10'h001;
      end
      // Step eight columns per frame, wrap past 2040
      if (frame_start & (frame_cnt_reg != 16'h0000))
        auto_pos_reg <= auto_pos_reg + AUTO_CURSOR_STEP;
      if (pix_rise & lv) begin
        walk_half_reg <= ~walk_h;
        walk_step_reg <= walk_wrap ? 4'h0 : (walk_h ? walk_k + 4'h1 : walk_k);
      end
    end
  end

  // Link outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pclk_out_reg <= 1'b0;
      frame_valid_out <= 1'b0;
      line_valid_out <= 1'b0;
      pixel_out <= 10'h000;
      ten_bit_raw_format <= 1'b1;
      eight_bit_raw_format <= 1'b0;
      packing_bypass <= 1'b0;
      frame_descriptor <= DESC_WITH_EMBEDDED;
    end else begin
      pclk_out_reg <= pclk_lvl_reg;
      if (pix_rise) begin
        frame_valid_out <= fv;
        line_valid_out <= out_lv;
        pixel_out <= out_pix;
      end
      // Ten-bit raw forced in PRBS mode
      ten_bit_raw_format <= is_prbs | ~format_reg;
      eight_bit_raw_format <= ~is_prbs & format_reg;
      packing_bypass <= is_prbs;
      frame_descriptor <= is_prbs ? DESC_NO_EMBEDDED : DESC_WITH_EMBEDDED;
    end
  end

  assign pixel_clock_out = pclk_out_reg;
endmodule // tpg_top

// file: hw/tpg_pkg.sv
// Constants shared by the test pattern and cursor generator.
package tpg_pkg;
  localparam int ADDR_W = 4;
  localparam int PIX_W = 10;
  localparam int COORD_W = 12;
  // Word indices of the register map
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_FILL_RED = 4'h1;
  localparam logic [3:0] REG_FILL_GR = 4'h2;
  localparam logic [3:0] REG_FILL_BLUE = 4'h3;
  localparam logic [3:0] REG_FILL_GB = 4'h4;
  localparam logic [3:0] REG_HCUR_POS = 4'h5;
  localparam logic [3:0] REG_HCUR_WIDTH = 4'h6;
  localparam logic [3:0] REG_VCUR_POS = 4'h7;
  localparam logic [3:0] REG_VCUR_WIDTH = 4'h8;
  localparam logic [3:0] REG_ORIENT = 4'h9;
  localparam logic [3:0] REG_X_START = 4'hA;
  localparam logic [3:0] REG_FORMAT = 4'hB;
  localparam logic [3:0] REG_STATUS = 4'hC;
  localparam logic [3:0] REG_FRAMES = 4'hD;
  // Field positions
  localparam int ORIENT_COL_REV_BIT = 0;
  localparam int ORIENT_ROW_FLIP_BIT = 1;
  localparam int FORMAT_EIGHT_BIT = 0;
  // Pattern codes
  localparam logic [8:0] MODE_NORMAL = 9'h000;
  localparam logic [8:0] MODE_SOLID = 9'h001;
  localparam logic [8:0] MODE_BARS = 9'h002;
  localparam logic [8:0] MODE_FADE = 9'h003;
  localparam logic [8:0] MODE_PRBS = 9'h004;
  localparam logic [8:0] MODE_WALK10 = 9'h100;
  localparam logic [8:0] MODE_WALK8 = 9'h101;
  // Values
  localparam logic [9:0] FULL_SCALE = 10'h3FF;
  localparam logic [9:0] EIGHT_FULL = 10'h0FF;
  localparam logic [11:0] AUTO_CURSOR_CODE = 12'hFFF;
  localparam logic [10:0] AUTO_CURSOR_STEP = 11'h008;
  localparam logic [15:0] DESC_WITH_EMBEDDED = 16'h1002;
  localparam logic [15:0] DESC_NO_EMBEDDED = 16'h1000;
  localparam logic [8:0] PRBS_SEED = 9'h1FF;
  localparam logic [3:0] WALK_LAST10 = 4'hB;
  localparam logic [3:0] WALK_LAST8 = 4'h9;
  // Reset values
  localparam logic [8:0] RST_MODE = 9'h000;
  localparam logic [9:0] RST_FILL = 10'h000;
  localparam logic [11:0] RST_COORD = 12'h000;
endpackage

// file: hw/tpg_prbs9.sv
// Nine-bit PRBS generator producing one ten-bit word per step.
`timescale 1ns/1ns
module tpg_prbs9 (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic step,
  // Current word
  output logic [tpg_pkg::PIX_W-1:0] word
);
  import tpg_pkg::*;

  logic [8:0] state_reg;
  logic [8:0] state_next;

  // Runs ten shifts; bits leave at bit 8 and fill the word from bit 0
  function automatic logic [18:0] run10(input logic [8:0] s);
    logic [8:0] st;
    logic [9:0] w;
    st = s;
    w = 10'h000;
    for (int i = 0; i < PIX_W; i++) begin
      w[i] = st[8];
      st = {st[7:0], st[8] ^ st[3]};
    end
    return {w, st};
  endfunction

  assign {word, state_next} = run10(state_reg);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= PRBS_SEED;
    end else if (load) begin
      state_reg <= PRBS_SEED;
    end else if (step) begin
      state_reg <= state_next;
    end
  end
endmodule // tpg_prbs9

// file: tb/tpg_top_asserts.sv
// Concurrent checks on the pattern generator ports.
`timescale 1ns/1ns
module tpg_top_asserts (
  // Clock, reset and bus
  input wire logic core_clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Pixel link
  input wire logic pixel_clock_out,
  input wire logic frame_valid_out,
  input wire logic line_valid_out,
  input wire logic [tpg_pkg::PIX_W-1:0] pixel_out,
  input wire logic ten_bit_raw_format,
  input wire logic eight_bit_raw_format,
  input wire logic packing_bypass,
  input wire logic [15:0] frame_descriptor
);
  import tpg_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_edge;
    $rose(pixel_clock_out);
  endsequence
  sequence s_hold;
    ($stable(pixel_out) && $stable(line_valid_out)) [*4];
  endsequence
  AST_BUS_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait is not one cycle");
  AST_WORD_HOLD: assert property (s_edge |=> s_hold)
    else $error("pixel word not held for its pixel clock");
  AST_DATA_CLK: assert property ($changed(pixel_out) |=> s_edge)
    else $error("pixel word change without pixel clock rise");
  AST_VALID_CLK: assert property ($changed(line_valid_out) || $changed(frame_valid_out) |=> s_edge)
    else $error("valid change without pixel clock rise");
  AST_DESC: assert property (frame_descriptor == (packing_bypass ? DESC_NO_EMBEDDED : DESC_WITH_EMBEDDED))
    else $error("descriptor does not follow prbs mode");
  AST_RAW: assert property (packing_bypass |-> ten_bit_raw_format)
    else $error("prbs mode not ten-bit raw");
  AST_FMT: assert property (eight_bit_raw_format != ten_bit_raw_format)
    else $error("format flags not exclusive");
  AST_BLANK: assert property (!line_valid_out |-> pixel_out == 10'h000)
    else $error("blank pixel not zero");
endmodule // tpg_top_asserts
bind tpg_top tpg_top_asserts u_chk (.core_clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
  .pixel_clock_out, .frame_valid_out, .line_valid_out, .pixel_out, .ten_bit_raw_format,
  .eight_bit_raw_format, .packing_bypass, .frame_descriptor);

// file: tb/tpg_pix_src.sv
// Upstream pixel source feeding frames into the generator.
`timescale 1ns/1ns
module tpg_pix_src (
  // Control
  input wire logic go,
  input wire logic [1:0] emb,
  output logic busy,
  // Stream
  output logic pclk,
  output logic fv,
  output logic lv,
  output logic er,
  output logic [9:0] pix,
  output logic [11:0] row,
  output logic [11:0] col
);
  initial {busy, pclk, fv, lv, er, pix, row, col} = '0;
  always #160 pclk = ~pclk;
  always @(posedge go) begin
    busy = 1;
    @(negedge pclk);
    fv = 1;
    for (int l = 0; l < emb + 4; l++) begin
      repeat (2) @(negedge pclk);
      er = l < emb;
      row = er ? 12'h000 : 12'(l - emb);
      lv = 1;
      for (int k = 0; k < 24; k++) begin
        col = 12'(k * 129);
        pix = col[9:0];
        @(negedge pclk);
      end
      lv = 0;
      er = 0;
      pix = ~pix;
    end
    repeat (2) @(negedge pclk);
    fv = 0;
    repeat (4) @(negedge pclk);
    busy = 0;
  end
endmodule // tpg_pix_src

// file: tb/test_test_pattern_and_cursor_gen.sv
// Self-checking bench for the pattern generator.
`timescale 1ns/1ns
module test_test_pattern_and_cursor_gen;
  import tpg_pkg::*;
  logic core_clk = 0, rst = 1, avs_read = 0, avs_write = 0, go = 0, rv = 0, cur = 0, pco_q = 0;
  logic [ADDR_W+1:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata;
  logic [1:0] emb = '0;
  logic avs_waitrequest, busy, pclk, fv, lv, er, pixel_clock_out, frame_valid_out;
  logic line_valid_out, ten_bit_raw_format, eight_bit_raw_format, packing_bypass;
  logic [9:0] pix, pixel_out, f [4], cap [8][24];
  logic [11:0] row, col;
  logic [15:0] frame_descriptor;
  int err_total = 0, num_checks = 0, nl = 0, np = 0, cyc = 0;
  localparam logic [2:0] BARS [8] = '{3'h7, 3'h6, 3'h3, 3'h2, 3'h5, 3'h4, 3'h1, 3'h0};
  always #20 core_clk = ~core_clk;
  tpg_top u_dut (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .pix_clk_in(pclk),
    .frame_valid_in(fv), .line_valid_in(lv), .embedded_row_in(er), .pixel_in(pix),
    .array_row_in(row), .array_col_in(col), .pixel_clock_out, .frame_valid_out,
    .line_valid_out, .pixel_out, .ten_bit_raw_format, .eight_bit_raw_format,
    .packing_bypass, .frame_descriptor);
  tpg_pix_src u_src (.go, .emb, .busy, .pclk, .fv, .lv, .er, .pix, .row, .col);
  // Capture each word at the link clock rise
  always @(posedge core_clk) begin
    pco_q <= pixel_clock_out;
    cyc++;
    if (cyc == 40000) begin
      bad("timeout");
      close_out;
    end
    if (pixel_clock_out === 1'b1 && pco_q === 1'b0) begin
      if (line_valid_out === 1'b1 && nl < 8 && np < 24) cap[nl][np++] = pixel_out;
      else if (line_valid_out !== 1'b1 && np > 0) begin
        nl++;
        np = 0;
      end
    end
  end
  task automatic bad(input string m);
    $display("[ERR] %0t %s", $time, m);
    err_total++;
  endtask
  task automatic eq(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e) bad(m);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= {a, 2'b00};
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge core_clk);
    if (n >= 50) bad("bus stall");
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic ck(input logic [3:0] a, input logic [31:0] e, input string m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    eq(q, e, m);
  endtask
  task automatic frame(input logic [1:0] e);
    int n;
    n = 0;
    nl = 0;
    np = 0;
    emb <= e;
    go <= 1;
    @(posedge core_clk);
    go <= 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (busy !== 1'b0 && n < 5000);
    repeat (16) @(posedge core_clk);
  endtask
  function automatic logic [9:0] ex(input logic [8:0] m, input int r, input int k);
    logic [11:0] c;
    logic [1:0] s;
    logic [2:0] g;
    logic on;
    int h, v, t;
    c = 12'(k * 129);
    s = {1'(r), c[0]};
    g = BARS[c[10:8] ^ {3{rv}}];
    on = s == 2'h1 ? g[2] : s == 2'h2 ? g[0] : g[1];
    h = (c[7] ? r & ~15 : r) >> 1;
    t = m == MODE_WALK10 ? 11 : 9;
    v = (k >> 1) % (t + 1);
    case (m)
      MODE_SOLID: return f[s];
      MODE_BARS: return on ? FULL_SCALE : 10'h000;
      MODE_FADE: return on ? FULL_SCALE - 10'(h) : 10'(h);
      MODE_NORMAL: return cur && (r >= 2 || c == 12'h102) ? f[s] : c[9:0];
      default: return v == 0 ? 10'h000 : v == t ? (t == 11 ? FULL_SCALE : EIGHT_FULL)
                                                : 10'(1 << (v - 1));
    endcase
  endfunction
  task automatic chkf(input logic [8:0] m, input int e, input string s);
    eq(nl, e + 4, s);
    for (int j = 0; j < e + 4; j++) begin
      for (int k = 0; k < 24; k++) eq(cap[j][k], j < e ? 10'(k * 129) : ex(m, j - e, k), s);
    end
  endtask
  task automatic t_regs;
    ck(REG_MODE, 32'h0, "mode reset");
    wr(REG_FILL_RED, 32'hFFFF_FFFF);
    ck(REG_FILL_RED, 32'h3FF, "fill width");
    wr(REG_FRAMES, 32'h1234);
    ck(REG_FRAMES, 32'h0, "frames read-only");
    wr(4'hE, 32'h5A5A);
    ck(4'hE, 32'h0, "unmapped word");
  endtask
  task automatic t_normal;
    for (int s = 0; s < 4; s++) begin
      f[s] = 10'h080 + 10'(s);
      wr(s == 0 ? REG_FILL_GR : s == 1 ? REG_FILL_RED : 4'(s + 1), 32'(f[s]));
    end
    wr(REG_HCUR_POS, 32'h2);
    wr(REG_HCUR_WIDTH, 32'h2);
    wr(REG_VCUR_POS, 32'h103);
    wr(REG_VCUR_WIDTH, 32'h3);
    cur = 1;
    frame(2);
    chkf(MODE_NORMAL, 2, "cursor overlay");
    wr(REG_HCUR_WIDTH, 32'h0);
    wr(REG_VCUR_WIDTH, 32'h0);
    cur = 0;
    frame(2);
    chkf(MODE_NORMAL, 2, "cursor hidden");
  endtask
  task automatic t_solid;
    wr(REG_MODE, 32'(MODE_SOLID));
    frame(2);
    chkf(MODE_SOLID, 2, "solid fill");
  endtask
  task automatic t_bars;
    for (int i = 0; i < 7; i++) begin
      wr(REG_MODE, 32'(i < 3 ? MODE_BARS : MODE_FADE));
      wr(REG_ORIENT, 32'(i % 4));
      rv = i < 3 ? i == 1 : i % 4 != 0;
      frame(2);
      chkf(i < 3 ? MODE_BARS : MODE_FADE, 2, "bars");
    end
  endtask
  task automatic t_walk;
    for (int i = 0; i < 2; i++) begin
      wr(REG_MODE, 32'(i == 0 ? MODE_WALK10 : MODE_WALK8));
      frame(2);
      chkf(i == 0 ? MODE_WALK10 : MODE_WALK8, 2, "walking one");
    end
  endtask
  task automatic t_prbs;
    wr(REG_FORMAT, 32'h1);
    wr(REG_MODE, 32'(MODE_PRBS));
    frame(0);
    eq({cap[0][0], cap[0][1], cap[0][2]}, {10'h1FF, 10'h378, 10'h1A1}, "prbs words");
    frame(2);
    eq(nl, 4, "embedded rows dropped");
    eq({ten_bit_raw_format, packing_bypass, frame_descriptor}, {2'h3, DESC_NO_EMBEDDED}, "prbs fmt");
    eq(eight_bit_raw_format, 1'b0, "prbs eight-bit flag");
    wr(REG_MODE, 32'(MODE_NORMAL));
    frame(0);
    eq({ten_bit_raw_format, packing_bypass, frame_descriptor}, {2'h0, DESC_WITH_EMBEDDED}, "raw fmt");
    eq(eight_bit_raw_format, 1'b1, "raw eight-bit flag");
    ck(REG_FRAMES, 32'h0000_000F, "frame count");
    ck(REG_STATUS, 32'h0070_0100, "auto cursor step");
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    t_regs;
    t_normal;
    t_solid;
    t_bars;
    t_walk;
    t_prbs;
    close_out;
  end
endmodule // test_test_pattern_and_cursor_gen
